// *** rtl/lane_status_pkg.sv ***
// Package with register map, field positions and carrier types for the lane status bank
package lane_status_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int NUM_LANES = 2;

    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [DATA_W-1:0] byte_t;

    // Status register offsets
    localparam addr_t LANE5_LINK_STATUS_ADDR = 12'h4B5;
    localparam addr_t LANE6_LINK_STATUS_ADDR = 12'h4B6;
    // Control and interrupt registers
    localparam addr_t THRESHOLD_ADDR = 12'h4C0;
    localparam addr_t CONTROL_ADDR = 12'h4C1;
    localparam addr_t IRQ_STATUS_BASE = 12'h4C2;
    localparam addr_t IRQ_MASK_BASE = 12'h4C4;

    // Status and control field positions
    localparam int DISPARITY_ERR_BIT = 7;
    localparam int INVALID_CODE_BIT = 6;
    localparam int UNEXPECTED_CTRL_BIT = 5;
    localparam int DESKEW_OK_BIT = 4;
    localparam int INITIAL_ALIGN_OK_BIT = 3;
    localparam int CHECKSUM_OK_BIT = 2;
    localparam int FRAME_SYNC_OK_BIT = 1;
    localparam int CODEGROUP_SYNC_OK_BIT = 0;
    localparam int SKIP_ALIGN_BIT = 0;

    // Events: error flags on rise, sync flags on loss
    localparam byte_t RISE_EVENT_MASK = 8'hE0;
    localparam byte_t FALL_EVENT_MASK = 8'h1F;
    // Bits without meaning when the alignment sequence is skipped
    localparam byte_t ALIGN_DEPENDENT_MASK = 8'h1E;

    // Reset values
    localparam byte_t LINK_STATUS_RESET = 8'h00;
    localparam byte_t THRESHOLD_RESET = 8'hFF;
    localparam byte_t CONTROL_RESET = 8'h00;
    localparam byte_t IRQ_STATUS_RESET = 8'h00;
    localparam byte_t IRQ_MASK_RESET = 8'h00;
    localparam byte_t READ_IDLE = 8'h00;

    typedef struct packed {
        byte_t disparity;
        byte_t invalid_code;
        byte_t unexpected_ctrl;
    } lane_err_counts_s;

    typedef struct packed {
        logic deskew_ok;
        logic initial_align_ok;
        logic checksum_ok;
        logic frame_sync_ok;
        logic codegroup_sync_ok;
    } lane_sync_s;

    typedef struct packed {
        byte_t [NUM_LANES-1:0] link_status;
        byte_t [NUM_LANES-1:0] irq_status;
        byte_t [NUM_LANES-1:0] irq_mask;
        byte_t error_count_threshold;
        logic skip_alignment_sequence;
        byte_t rdata;
    } bank_state_s;

endpackage : lane_status_pkg

// *** rtl/lane_status_eval.sv ***
// Live status byte of one lane from its counters and sync state
`timescale 1ns/1ps
`default_nettype none

module lane_status_eval
    import lane_status_pkg::*;
(
    input wire lane_err_counts_s counts,
    input wire lane_sync_s sync,
    input wire byte_t error_count_threshold,
    output logic [DATA_W-1:0] status
);

    always_comb begin
        status = LINK_STATUS_RESET;
        // Inclusive compare: a count equal to the threshold already flags
        status[DISPARITY_ERR_BIT] = (counts.disparity >= error_count_threshold);
        status[INVALID_CODE_BIT] = (counts.invalid_code >= error_count_threshold);
        status[UNEXPECTED_CTRL_BIT] = (counts.unexpected_ctrl >= error_count_threshold);
        status[DESKEW_OK_BIT] = sync.deskew_ok;
        status[INITIAL_ALIGN_OK_BIT] = sync.initial_align_ok;
        status[CHECKSUM_OK_BIT] = sync.checksum_ok;
        status[FRAME_SYNC_OK_BIT] = sync.frame_sync_ok;
        status[CODEGROUP_SYNC_OK_BIT] = sync.codegroup_sync_ok;
    end

endmodule : lane_status_eval

`default_nettype wire

// *** rtl/lane_link_status_regs.sv ***
// Lane 5 and 6 link status register bank with threshold, mode and interrupt logic
//
// Notes on behaviour
// - Bit 7 is one while the lane's bad disparity count is at or above the threshold, else zero.
// - Bit 6 is one while the lane's not-in-table count is at or above the threshold, else zero.
// - Bit 5 is one while the lane's unexpected control character count is at or above the threshold, else zero.
// - Bit 4 shows deskew achieved as one and failed as zero, and means nothing when alignment is skipped.
// - Bit 3 shows initial lane alignment achieved as one and lost as zero, ignored when alignment is skipped.
// - Bit 2 shows a correct configuration checksum as one and a wrong one as zero, ignored when skipped.
// - Bit 1 shows frame sync achieved as one and lost as zero, ignored when alignment is skipped.
// - Bit 0 shows code group sync achieved as one and lost as zero, valid in every mode.
// - One read-only status byte per lane, lane 5 at 0x4B5 and lane 6 at 0x4B6, same layout, reset to zero.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module lane_link_status_regs
    import lane_status_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_B,
    input wire addr_t ADDR,
    input wire byte_t WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [DATA_W-1:0] RDATA,
    input wire lane_err_counts_s [NUM_LANES-1:0] LANE_ERR_COUNTS,
    input wire lane_sync_s [NUM_LANES-1:0] LANE_SYNC,
    output logic SKIP_ALIGNMENT_SEQUENCE,
    output logic IRQ
);

    bank_state_s s_q;
    bank_state_s s_d;
    byte_t [NUM_LANES-1:0] live_status;

    // Index of lane register at base plus lane, or NUM_LANES when no hit
    function automatic int lane_hit(input addr_t addr, input addr_t base);
        int idx;
        idx = NUM_LANES;
        for (int i = 0; i < NUM_LANES; i++) begin
            if (addr == base + addr_t'(i)) begin
                idx = i;
            end
        end
        return idx;
    endfunction : lane_hit

    genvar g;
    generate
        for (g = 0; g < NUM_LANES; g++) begin : g_lane
            lane_status_eval u_eval (
                .counts(LANE_ERR_COUNTS[g]),
                .sync(LANE_SYNC[g]),
                .error_count_threshold(s_q.error_count_threshold),
                .status(live_status[g])
            );
        end
    endgenerate

    always_comb begin
        byte_t events;
        byte_t clear;
        byte_t ignore;
        int hit;
        events = 8'h00;
        clear = 8'h00;
        ignore = 8'h00;
        hit = NUM_LANES;
        s_d = s_q;

        // Alignment-dependent bits raise no events while the sequence is skipped
        ignore = s_q.skip_alignment_sequence ? ALIGN_DEPENDENT_MASK : 8'h00;

        for (int i = 0; i < NUM_LANES; i++) begin
            // Refreshed every cycle; no latching of past values
            s_d.link_status[i] = live_status[i];
            events = ((live_status[i] & ~s_q.link_status[i] & RISE_EVENT_MASK)
                | (~live_status[i] & s_q.link_status[i] & FALL_EVENT_MASK)) & ~ignore;
            clear = 8'h00;
            if (WR && (lane_hit(ADDR, IRQ_STATUS_BASE) == i)) begin
                clear = WDATA;
            end
            // Set wins over a clear in the same cycle
            s_d.irq_status[i] = (s_q.irq_status[i] & ~clear) | events;
            if (WR && (lane_hit(ADDR, IRQ_MASK_BASE) == i)) begin
                s_d.irq_mask[i] = WDATA;
            end
        end

        // Writes to the status bytes fall through unused
        if (WR) begin
            if (ADDR == THRESHOLD_ADDR) begin
                s_d.error_count_threshold = WDATA;
            end
            if (ADDR == CONTROL_ADDR) begin
                s_d.skip_alignment_sequence = WDATA[SKIP_ALIGN_BIT];
            end
        end

        // Read data stand one cycle only; reads change no state
        s_d.rdata = READ_IDLE;
        if (RD) begin
            if (ADDR == LANE5_LINK_STATUS_ADDR) begin
                s_d.rdata = s_q.link_status[0];
            end else if (ADDR == LANE6_LINK_STATUS_ADDR) begin
                s_d.rdata = s_q.link_status[1];
            end else if (ADDR == THRESHOLD_ADDR) begin
                s_d.rdata = s_q.error_count_threshold;
            end else if (ADDR == CONTROL_ADDR) begin
                s_d.rdata = {7'h00, s_q.skip_alignment_sequence};
            end else begin
                hit = lane_hit(ADDR, IRQ_STATUS_BASE);
                if (hit < NUM_LANES) begin
                    s_d.rdata = s_q.irq_status[hit];
                end
                hit = lane_hit(ADDR, IRQ_MASK_BASE);
                if (hit < NUM_LANES) begin
                    s_d.rdata = s_q.irq_mask[hit];
                end
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            for (int i = 0; i < NUM_LANES; i++) begin
                s_q.link_status[i] <= LINK_STATUS_RESET;
                s_q.irq_status[i] <= IRQ_STATUS_RESET;
                s_q.irq_mask[i] <= IRQ_MASK_RESET;
            end
            s_q.error_count_threshold <= THRESHOLD_RESET;
            s_q.skip_alignment_sequence <= CONTROL_RESET[SKIP_ALIGN_BIT];
            s_q.rdata <= READ_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        IRQ = 1'b0;
        for (int i = 0; i < NUM_LANES; i++) begin
            IRQ = IRQ | (|(s_q.irq_status[i] & s_q.irq_mask[i]));
        end
    end

    assign RDATA = s_q.rdata;
    assign SKIP_ALIGNMENT_SEQUENCE = s_q.skip_alignment_sequence;

endmodule : lane_link_status_regs

`default_nettype wire

// *** verification/lane_link_props.sv ***
// Checker for the lane status register bank
`timescale 1ns/1ps
`default_nettype none
module lane_link_props
    import lane_status_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_B,
    input wire addr_t ADDR,
    input wire byte_t WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [DATA_W-1:0] RDATA,
    input wire lane_err_counts_s [NUM_LANES-1:0] LANE_ERR_COUNTS,
    input wire lane_sync_s [NUM_LANES-1:0] LANE_SYNC,
    input wire logic IRQ
);
    byte_t thr_q, x_q;
    byte_t [NUM_LANES-1:0] e_q;
    logic v_q;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    // Expected byte trails the lane inputs by two edges
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            {thr_q, x_q, e_q, v_q} <= {8'hFF, 25'h0};
        end else begin
            if (WR && ADDR == THRESHOLD_ADDR) thr_q <= WDATA;
            for (int i = 0; i < NUM_LANES; i++)
                e_q[i] <= {LANE_ERR_COUNTS[i].disparity >= thr_q, LANE_ERR_COUNTS[i].invalid_code >= thr_q,
                    LANE_ERR_COUNTS[i].unexpected_ctrl >= thr_q, LANE_SYNC[i]};
            x_q <= e_q[ADDR == LANE6_LINK_STATUS_ADDR];
            v_q <= RD && (ADDR == LANE5_LINK_STATUS_ADDR || ADDR == LANE6_LINK_STATUS_ADDR);
        end
    end
    chk_disp_flag: assert property (v_q |-> RDATA[7] == x_q[7]) else $error("bit 7 wrong");
    chk_code_flag: assert property (v_q |-> RDATA[6] == x_q[6]) else $error("bit 6 wrong");
    chk_ctrl_flag: assert property (v_q |-> RDATA[5] == x_q[5]) else $error("bit 5 wrong");
    chk_deskew_bit: assert property (v_q |-> RDATA[4] == x_q[4]) else $error("bit 4 wrong");
    chk_align_bit: assert property (v_q |-> RDATA[3] == x_q[3]) else $error("bit 3 wrong");
    chk_cksum_bit: assert property (v_q |-> RDATA[2] == x_q[2]) else $error("bit 2 wrong");
    chk_frame_bit: assert property (v_q |-> RDATA[1] == x_q[1]) else $error("bit 1 wrong");
    chk_cgs_bit: assert property (v_q |-> RDATA[0] == x_q[0]) else $error("bit 0 wrong");
    chk_rd_idle: assert property (!RD |=> RDATA == 8'h00) else $error("read data not idle");
    cover property (v_q && RDATA[7]);
    cover property (v_q && RDATA[0]);
    cover property (IRQ);
endmodule : lane_link_props
bind lane_link_status_regs lane_link_props u_props (.MCLK(MCLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .LANE_ERR_COUNTS(LANE_ERR_COUNTS), .LANE_SYNC(LANE_SYNC), .IRQ(IRQ));
`default_nettype wire

// *** verification/lane_tx_model.sv ***
// Transmitter side model driving lane counts and sync state
`timescale 1ns/1ps
`default_nettype none
module lane_tx_model
    import lane_status_pkg::*;
(
    input wire logic clk,
    output var lane_err_counts_s [NUM_LANES-1:0] cnt,
    output var lane_sync_s [NUM_LANES-1:0] sync
);
    initial {cnt, sync} = '0;
    // Changes land just after an edge, as from clocked link logic
    task automatic send(input int ln, input lane_err_counts_s c, input lane_sync_s s);
        @(posedge clk);
        cnt[ln] <= c;
        sync[ln] <= s;
    endtask : send
endmodule : lane_tx_model
`default_nettype wire

// *** verification/lane_link_status_regs_test.sv ***
// Bench for the lane status register bank
`timescale 1ns/1ps
`default_nettype none
module lane_link_status_regs_test
    import lane_status_pkg::*;
;
    logic mclk = 1'h0, rst_b = 1'h0, wr = 1'h0, rd = 1'h0, skip, irq;
    addr_t addr = 12'h000;
    byte_t wdata = 8'h00, rdata;
    lane_err_counts_s [NUM_LANES-1:0] cnt;
    lane_sync_s [NUM_LANES-1:0] sync;
    int num_errors = 0, tests_run = 0;
    always #10 mclk = ~mclk;
    lane_tx_model u_tx (.clk(mclk), .cnt(cnt), .sync(sync));
    lane_link_status_regs dut (.MCLK(mclk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .LANE_ERR_COUNTS(cnt), .LANE_SYNC(sync), .SKIP_ALIGNMENT_SEQUENCE(skip), .IRQ(irq));
    task automatic check(input string n, input byte_t seen, input byte_t exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    // Reads compare with d; returns once a write has landed
    task automatic bus(input logic w, input addr_t a, input byte_t d);
        @(posedge mclk);
        {wr, rd, addr, wdata} <= {w, !w, a, d};
        @(posedge mclk);
        {wr, rd} <= 2'h0;
        @(negedge mclk);
        if (!w) check("rdata", rdata, d);
    endtask : bus
    task automatic tally_and_finish;
        $display("%0d checks, %0d mismatches", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20) @(posedge mclk);
        rst_b <= 1'h1;
        bus(1'h0, LANE5_LINK_STATUS_ADDR, 8'h00);
        bus(1'h0, LANE6_LINK_STATUS_ADDR, 8'h00);
        bus(1'h0, 12'h123, 8'h00);
        $display("reset test done");
        bus(1'h1, THRESHOLD_ADDR, 8'h10);
        u_tx.send(0, {8'h10, 8'h0F, 8'h11}, 5'h15);
        u_tx.send(1, {8'h0F, 8'h10, 8'h0F}, 5'h0A);
        bus(1'h0, LANE5_LINK_STATUS_ADDR, 8'hB5);
        bus(1'h0, LANE6_LINK_STATUS_ADDR, 8'h4A);
        bus(1'h1, LANE5_LINK_STATUS_ADDR, 8'hFF);
        bus(1'h0, LANE5_LINK_STATUS_ADDR, 8'hB5);
        $display("threshold test done");
        bus(1'h1, IRQ_MASK_BASE, 8'h20);
        check("irq", {7'h00, irq}, 8'h01);
        bus(1'h1, IRQ_STATUS_BASE, 8'h20);
        check("irq", {7'h00, irq}, 8'h00);
        bus(1'h0, IRQ_STATUS_BASE, 8'h80);
        bus(1'h0, IRQ_STATUS_BASE + 12'h001, 8'h40);
        bus(1'h1, IRQ_MASK_BASE + 12'h001, 8'h40);
        check("irq", {7'h00, irq}, 8'h01);
        bus(1'h1, IRQ_STATUS_BASE + 12'h001, 8'h40);
        check("irq", {7'h00, irq}, 8'h00);
        $display("irq test done");
        u_tx.send(0, 24'h0, 5'h1F);
        bus(1'h0, LANE5_LINK_STATUS_ADDR, 8'h1F);
        bus(1'h1, CONTROL_ADDR, 8'h01);
        check("skip", {7'h00, skip}, 8'h01);
        bus(1'h0, LANE6_LINK_STATUS_ADDR, 8'h4A);
        // Loss of every sync bit while skipped: only code group loss raises an event
        u_tx.send(0, 24'h0, 5'h00);
        bus(1'h0, LANE5_LINK_STATUS_ADDR, 8'h00);
        bus(1'h0, IRQ_STATUS_BASE, 8'h81);
        $display("live test done");
        tally_and_finish();
    end
    initial begin
        repeat (500) @(posedge mclk);
        num_errors++;
        tally_and_finish();
    end
endmodule : lane_link_status_regs_test
`default_nettype wire
